// File: asc_sram_regs.svh
// timing constants and geometry for the static memory host controller
`ifndef ASC_SRAM_REGS_SVH
`define ASC_SRAM_REGS_SVH
`define ASC_ADDR_W 13
`define ASC_DATA_W 8
`define ASC_DEPTH 8192
`define ASC_CLK_PERIOD_NS 25
`define ASC_READ_CYCLE_MIN_NS 70
`define ASC_WRITE_PULSE_NS 50
`define ASC_DATA_SETUP_NS 30
`define ASC_ACCESS_NS 70
`define ASC_RECOVERY_NS 70
`define ASC_READ_CYC ((`ASC_READ_CYCLE_MIN_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_WRITE_CYC ((`ASC_WRITE_PULSE_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_ACCESS_CYC ((`ASC_ACCESS_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_RECOVERY_CYC ((`ASC_RECOVERY_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`endif

// File: asc_pkg.sv
// types shared by the static memory host controller
package asc_pkg;
   typedef enum logic [2:0] {
      ASC_IDLE = 3'b000,
      ASC_RD_SETUP = 3'b001,
      ASC_RD_WAIT = 3'b010,
      ASC_WR_SETUP = 3'b011,
      ASC_WR_PULSE = 3'b100,
      ASC_WR_END = 3'b101,
      ASC_RECOVER = 3'b110
   } asc_state_type;
endpackage

// File: asc_sync.sv
// two-stage synchroniser for the data bus coming back from the memory
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
   parameter int W = 8
) (
   // clock
   input wire logic ref_clk,
   // data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge ref_clk) begin
      meta_q <= async_in;
      sync_out <= meta_q;
   end
endmodule
`default_nettype wire

// File: asc_host.sv
// host controller driving an asynchronous 8k x 8 static memory
// Operation
// - access only with both chip selects asserted together
// - eight bidirectional data pins carry both directions
// - write interval is overlap of both selects and write strobe low
// - hold write data valid around the edge ending the write
// - host never drives bus while device may be driving
// - output enable held high throughout write cycles
// - address valid before or with chip selects going active
// - wait one read cycle time after retention before access
`timescale 1ns/1ps
`default_nettype none
`include "asc_sram_regs.svh"
module asc_host
   import asc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // user request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [`ASC_ADDR_W-1:0] req_addr,
   input wire logic [`ASC_DATA_W-1:0] req_wdata,
   input wire logic retention_exit,
   output logic req_ready,
   output logic rsp_valid,
   output logic [`ASC_DATA_W-1:0] rsp_rdata,
   // memory pins
   output logic [`ASC_ADDR_W-1:0] word_address,
   output logic chip_select_low_n,
   output logic chip_select_high,
   output logic output_enable_n,
   output logic write_strobe_n,
   input wire logic [`ASC_DATA_W-1:0] shared_data_bus_i,
   output logic [`ASC_DATA_W-1:0] shared_data_bus_o,
   output logic [`ASC_DATA_W-1:0] shared_data_bus_oe
);
   localparam logic [3:0] READ_CYC = 4'(`ASC_READ_CYC);
   localparam logic [3:0] WRITE_CYC = 4'(`ASC_WRITE_CYC);
   localparam logic [3:0] ACCESS_CYC = 4'(`ASC_ACCESS_CYC);
   localparam logic [3:0] RECOVERY_CYC = 4'(`ASC_RECOVERY_CYC);

   asc_state_type state_q;
   logic [3:0] cnt_q;
   logic sel_q;
   logic [`ASC_DATA_W-1:0] bus_sync;
   logic drive_q;

   // pin data is asynchronous to ref_clk, two flops before use
   asc_sync #(.W(`ASC_DATA_W)) u_sync (
      .ref_clk(ref_clk),
      .async_in(shared_data_bus_i),
      .sync_out(bus_sync)
   );

   // sync adds two cycles of latency to the sampled read data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= ASC_IDLE;
         cnt_q <= 4'h0;
      end else begin
         case (state_q)
            ASC_IDLE: begin
               if (retention_exit) begin
                  state_q <= ASC_RECOVER;
                  cnt_q <= RECOVERY_CYC;
               end else if (req_valid && req_write) begin
                  state_q <= ASC_WR_SETUP;
                  cnt_q <= 4'h0;
               end else if (req_valid) begin
                  state_q <= ASC_RD_SETUP;
                  cnt_q <= 4'h0;
               end
            end
            ASC_RD_SETUP: begin
               state_q <= ASC_RD_WAIT;
               cnt_q <= ACCESS_CYC + 4'h2;
            end
            ASC_RD_WAIT: begin
               if (cnt_q == 4'h1) begin
                  state_q <= ASC_IDLE;
               end
               cnt_q <= cnt_q - 4'h1;
            end
            ASC_WR_SETUP: begin
               state_q <= ASC_WR_PULSE;
               cnt_q <= (WRITE_CYC > READ_CYC) ? WRITE_CYC : READ_CYC;
            end
            ASC_WR_PULSE: begin
               if (cnt_q == 4'h1) begin
                  state_q <= ASC_WR_END;
               end
               cnt_q <= cnt_q - 4'h1;
            end
            ASC_WR_END: begin
               state_q <= ASC_IDLE;
            end
            ASC_RECOVER: begin
               if (cnt_q == 4'h1) begin
                  state_q <= ASC_IDLE;
               end
               cnt_q <= cnt_q - 4'h1;
            end
            default: begin
               state_q <= ASC_IDLE;
            end
         endcase
      end
   end

   // latch address and write data when a request is taken
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         word_address <= '0;
         shared_data_bus_o <= '0;
      end else if (state_q == ASC_IDLE && req_valid && !retention_exit) begin
         word_address <= req_addr;
         shared_data_bus_o <= req_wdata;
      end
   end

   // selects assert one cycle after the address settles
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= (state_q == ASC_RD_SETUP) || (state_q == ASC_RD_WAIT
            && cnt_q != 4'h1) || (state_q == ASC_WR_SETUP)
            || (state_q == ASC_WR_PULSE);
      end
   end
   assign chip_select_low_n = !sel_q;
   assign chip_select_high = sel_q;

   // strobe inside select window, ignores output enable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         write_strobe_n <= 1'b1;
      end else begin
         write_strobe_n <= !(state_q == ASC_WR_SETUP
            || (state_q == ASC_WR_PULSE && cnt_q != 4'h1));
      end
   end

   // output enable only for reads, never during a write
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         output_enable_n <= 1'b1;
      end else begin
         output_enable_n <= !(state_q == ASC_RD_SETUP || (state_q ==
            ASC_RD_WAIT && cnt_q != 4'h1));
      end
   end

   // host drives bus through whole write plus one cycle hold after end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= (state_q == ASC_WR_SETUP) || (state_q == ASC_WR_PULSE);
      end
   end
   assign shared_data_bus_oe = {`ASC_DATA_W{drive_q}};

   // capture read byte at end of access window
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= (state_q == ASC_RD_WAIT && cnt_q == 4'h1);
         if (state_q == ASC_RD_WAIT && cnt_q == 4'h1) begin
            rsp_rdata <= bus_sync;
         end
      end
   end

   assign req_ready = (state_q == ASC_IDLE) && !retention_exit;

   chk_drive_no_oe: assert property (@(posedge ref_clk) disable iff (rst)
      drive_q |-> output_enable_n)
      else $error("host drives bus while output enable active");
   chk_we_inside_sel: assert property (@(posedge ref_clk) disable iff (rst)
      !write_strobe_n |-> sel_q)
      else $error("write strobe outside select");
   chk_we_oe_excl: assert property (@(posedge ref_clk) disable iff (rst)
      !write_strobe_n |-> output_enable_n)
      else $error("output enable low during write");
   chk_data_hold: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(write_strobe_n) |-> drive_q)
      else $error("write data dropped at write end");
   chk_addr_stable: assert property (@(posedge ref_clk) disable iff (rst)
      sel_q && $past(sel_q) |-> $stable(word_address))
      else $error("address changed while selected");
   chk_recover_wait: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ASC_IDLE && retention_exit |=> !sel_q [*3])
      else $error("access before recovery time");
   chk_sel_pair: assert property (@(posedge ref_clk) disable iff (rst)
      chip_select_high && !chip_select_low_n |-> state_q != ASC_IDLE
      && state_q != ASC_RECOVER)
      else $error("chip selects active outside an access");
   chk_read_rsp: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ASC_RD_SETUP |-> ##6 rsp_valid)
      else $error("read response not on time");
endmodule
`default_nettype wire

// File: asc_sram_model.sv
// behavioural model of the 8k x 8 static memory on the far side
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
   // memory pins
   input wire logic [12:0] word_address,
   input wire logic chip_select_low_n,
   input wire logic chip_select_high,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   // data bus
   input wire logic [7:0] host_data,
   input wire logic [7:0] host_oe,
   output logic [7:0] bus_level,
   output logic fault = 1'b0
);
   logic [7:0] mem [0:8191];
   logic [7:0] last = 8'h00;
   wire sel = !chip_select_low_n && chip_select_high;
   wire wr = sel && !write_strobe_n;
   wire rd = sel && !output_enable_n && write_strobe_n;
   // level driven store, last level before the ending edge wins
   always @(wr or word_address or bus_level) begin
      if (wr) mem[word_address] = bus_level;
   end
   // no pull on the bus: a floating bus shows the inverse of its last level
   always @* begin
      if (|host_oe) bus_level = host_data;
      else if (rd) bus_level = mem[word_address];
      else bus_level = ~last;
   end
   always @(bus_level) begin
      if (|host_oe || rd) last = bus_level;
   end
   logic [12:0] held_a = 13'h0000;
   // contention, or address moving while selected
   always @(rd or host_oe or word_address or sel) begin
      if (rd && |host_oe) fault = 1'b1;
      if (sel && word_address !== held_a) fault = 1'b1;
      if (!sel) held_a = word_address;
   end
endmodule
`default_nettype wire

// File: asc_host_tb.sv
// self-checking testbench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module asc_host_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [12:0] req_addr = 13'h0000;
   logic [7:0] req_wdata = 8'h00;
   logic retention_exit = 1'b0;
   logic req_ready, rsp_valid, chip_select_low_n, chip_select_high;
   logic output_enable_n, write_strobe_n, fault;
   logic [7:0] rsp_rdata, shared_data_bus_i, shared_data_bus_o;
   logic [7:0] shared_data_bus_oe;
   logic [12:0] word_address;
   logic [12:0] cur_a = 13'h0000;
   int fails = 0;
   int compares = 0;
   int n;
   always #12.5 ref_clk = ~ref_clk;
   asc_host dut (.ref_clk, .rst, .req_valid, .req_write, .req_addr,
      .req_wdata, .retention_exit, .req_ready, .rsp_valid, .rsp_rdata,
      .word_address, .chip_select_low_n, .chip_select_high,
      .output_enable_n, .write_strobe_n, .shared_data_bus_i,
      .shared_data_bus_o, .shared_data_bus_oe);
   asc_sram_model mem (.word_address, .chip_select_low_n,
      .chip_select_high, .output_enable_n, .write_strobe_n,
      .host_data(shared_data_bus_o), .host_oe(shared_data_bus_oe),
      .bus_level(shared_data_bus_i), .fault);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task summarize;
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // bounded wait for completion, counted in cycles
   task wt(input bit r, output int k);
      k = 0;
      while (!(r ? rsp_valid : req_ready) && k < 30) begin
         @(negedge ref_clk);
         k++;
      end
      if (k >= 30) begin
         fails++;
         summarize();
      end
   endtask
   task go(input logic w, input logic [12:0] a, input logic [7:0] d);
      cur_a = a;
      chk(req_ready, 1'b1);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(negedge ref_clk);
      req_valid = 1'b0;
      wt(!w, n);
      // write: setup, longer of pulse and cycle, end; read: setup, access plus sync
      chk(16'(n), w ? 16'h0005 : 16'h0006);
   endtask
   task rd(input logic [12:0] a, input logic [7:0] e);
      go(1'b0, a, 8'h00);
      chk(rsp_rdata, e);
   endtask
   task t_bounds;
      go(1'b1, 13'h0000, 8'hA5);
      go(1'b1, 13'h1FFF, 8'h5A);
      go(1'b1, 13'h0011, 8'h22);
      rd(13'h1FFF, 8'h5A);
      rd(13'h0000, 8'hA5);
      go(1'b1, 13'h0000, 8'hC3);
      rd(13'h0000, 8'hC3);
   endtask
   // a request while busy must be ignored, not latched
   task t_refuse;
      cur_a = 13'h0010;
      chk(req_ready, 1'b1);
      req_valid = 1'b1;
      req_write = 1'b1;
      req_addr = 13'h0010;
      req_wdata = 8'h11;
      @(negedge ref_clk);
      req_addr = 13'h0011;
      req_wdata = 8'hEE;
      repeat (3) @(negedge ref_clk);
      req_valid = 1'b0;
      wt(1'b0, n);
      rd(13'h0011, 8'h22);
      rd(13'h0010, 8'h11);
   endtask
   task t_retain;
      retention_exit = 1'b1;
      @(negedge ref_clk);
      retention_exit = 1'b0;
      chk(chip_select_low_n, 1'b1);
      wt(1'b0, n);
      chk(n >= 3, 1'b1);
      rd(13'h1FFF, 8'h5A);
   endtask
   always @(negedge ref_clk) begin
      if (!rst) begin
         chk(chip_select_high, !chip_select_low_n);
         if (!chip_select_low_n) chk(word_address, cur_a);
         if (!write_strobe_n) chk({output_enable_n, shared_data_bus_oe},
            {1'b1, 8'hFF});
         if (!output_enable_n) chk(shared_data_bus_oe, 8'h00);
      end
   end
   initial begin
      repeat (6) @(negedge ref_clk);
      chk({chip_select_low_n, output_enable_n, write_strobe_n,
         shared_data_bus_oe, rsp_valid}, {3'b111, 8'h00, 1'b0});
      rst = 1'b0;
      @(negedge ref_clk);
      t_bounds();
      t_refuse();
      t_retain();
      chk(fault, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
